// ---- rtl/cdm_delay_manager.sv ----
// Commutation delay manager: step timer, captures, compare and pin setup.
// Assumes an Avalon-MM master on clk and event pulses from logic on clk.
`timescale 1ns/10ps
module cdm_delay_manager
   import cdm_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Events from detection logic
   input  wire logic        zero_cross_hw,
   input  wire logic        demag_hw,
   // Rotor position pins
   input  wire logic        rotor_input_a,
   input  wire logic        rotor_input_b,
   input  wire logic        rotor_input_c,
   // Pin configuration
   output logic [2:0]       rotor_digital,
   output logic [2:0]       pin_analog_sel,
   output logic [2:0]       pin_digital_sel,
   output logic [2:0]       pin_std_io,
   output logic [2:0]       pin_ground_o,
   output logic [2:0]       pin_ground_oe,
   output logic             phase_comp_on,
   // Event outputs
   output logic             commutation_event,
   output logic             sim_zero_event,
   output logic             sim_demag_event,
   output logic             speed_mode
);
   typedef struct packed {
      cdm_bus_t    bus;
      logic [31:0] rdata;
      logic [7:0]  pincfg;
      logic [7:0]  mode;
      logic [3:0]  ratio;
      logic [15:0] presc;
      logic [7:0]  timer;
      logic [7:0]  demag;
      logic [7:0]  zlatest;
      logic [7:0]  zprev;
      logic [7:0]  compare;
      logic [7:0]  weight;
      logic [3:0]  status;
      logic        sw_armed;
      logic        hw_armed;
      logic [1:0]  mult_pend;
      logic        comm_pulse;
      logic        zsim_pulse;
      logic        dsim_pulse;
      logic [2:0]  analog;
      logic [2:0]  digital;
      logic [2:0]  stdio;
      logic [2:0]  ground;
      logic        comp_on;
   } cdm_state_t;

   cdm_state_t st_reg;
   cdm_state_t st_next;

   logic [2:0] pin_raw;
   logic [2:0] pin_level;
   logic [7:0] mult_out;
   logic [7:0] mult_src;

   // Pin synchronisers
   assign pin_raw = {rotor_input_c, rotor_input_b, rotor_input_a};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_sync
         cdm_sync3 u_sync (
            .clk       (clk),
            .resetn    (resetn),
            .pin_in    (pin_raw[gi]),
            .level_out (pin_level[gi])
         );
      end
   endgenerate

   // Capture chosen by the capture select bit
   assign mult_src = st_reg.mode[CDM_MD_DCB] ? st_reg.zlatest : st_reg.zprev;

   cdm_mult8 u_mult (
      .clk        (clk),
      .resetn     (resetn),
      .factor_a   (st_reg.weight),
      .factor_b   (mult_src),
      .scaled_out (mult_out)
   );

   // Next-state logic
   always_comb
   begin
      logic       acc;
      logic       wr;
      logic       release_b;
      logic       sensor_b;
      logic [1:0] tacho_edge_select;
      logic [1:0] insel;
      logic       six_step;
      logic       cke;
      logic       tick;
      logic [15:0] mask;
      logic       c_evt;
      logic       zs_evt;
      logic       z_evt;
      logic [7:0] wbyte;
      logic [2:0] onehot;
      acc       = 1'b0;
      wr        = 1'b0;
      release_b = 1'b0;
      sensor_b  = 1'b0;
      tacho_edge_select       = 2'h0;
      insel     = 2'h0;
      six_step  = 1'b0;
      cke       = 1'b0;
      tick      = 1'b0;
      mask      = 16'h0000;
      c_evt     = 1'b0;
      zs_evt    = 1'b0;
      z_evt     = 1'b0;
      wbyte     = avs_writedata[7:0];
      onehot    = 3'h0;
      st_next   = st_reg;

      release_b = st_reg.pincfg[CDM_PC_RELEASE];
      sensor_b  = st_reg.pincfg[CDM_PC_SENSOR];
      tacho_edge_select       = st_reg.pincfg[CDM_PC_TES_LO +: 2];
      insel     = st_reg.pincfg[CDM_PC_IS_LO +: 2];
      six_step  = (tacho_edge_select == 2'h0);
      cke       = st_reg.mode[CDM_MD_CKE];

      // Bus answer: one wait cycle, then data and write strobe
      acc = (avs_read | avs_write) && (st_reg.bus == CDM_BUS_ACK);
      wr  = acc & avs_write;

      // Status clears first, so hardware sets below always win
      if (wr && avs_address == CDM_OFF_STATUS)
      begin
         st_next.status = st_reg.status & ~wbyte[3:0];
      end
      unique case (st_reg.bus)
         CDM_BUS_IDLE:
         begin
            if (avs_read | avs_write)
            begin
               st_next.bus = CDM_BUS_ACK;
            end
         end
         CDM_BUS_ACK:
         begin
            st_next.bus = CDM_BUS_IDLE;
         end
      endcase

      // Read data captured while waitrequest is high
      st_next.rdata = 32'h0000_0000;
      unique case (avs_address)
         CDM_OFF_PINCFG:  st_next.rdata[7:0] = st_reg.pincfg;
         CDM_OFF_MODE:    st_next.rdata[7:0] = st_reg.mode;
         CDM_OFF_RATIO:   st_next.rdata[3:0] = st_reg.ratio;
         CDM_OFF_TIMER:   st_next.rdata[7:0] = st_reg.timer;
         CDM_OFF_DEMAG:   st_next.rdata[7:0] = st_reg.demag;
         CDM_OFF_ZLATEST: st_next.rdata[7:0] = st_reg.zlatest;
         CDM_OFF_ZPREV:   st_next.rdata[7:0] = st_reg.zprev;
         CDM_OFF_COMPARE: st_next.rdata[7:0] = st_reg.compare;
         CDM_OFF_WEIGHT:  st_next.rdata[7:0] = st_reg.weight;
         CDM_OFF_STATUS:  st_next.rdata[3:0] = st_reg.status;
         default:         st_next.rdata = 32'h0000_0000;
      endcase

      // Prescaler tick, gated by the clock enable
      mask = 16'((17'h1 << st_reg.ratio) - 17'h1);
      if (cke)
      begin
         if (st_reg.presc >= mask)
         begin
            st_next.presc = 16'h0000;
            tick = 1'b1;
         end
         else
         begin
            st_next.presc = st_reg.presc + 16'h0001;
         end
      end

      // Zero-cross events, hardware and simulated
      zs_evt = cke & st_reg.mode[CDM_MD_ZSIM] & (st_reg.timer == st_reg.zlatest)
               & (st_reg.zlatest != 8'h00);
      z_evt  = zero_cross_hw | zs_evt;

      // Commutation match per mode
      if (cke && six_step)
      begin
         if (st_reg.mode[CDM_MD_SC])
         begin
            c_evt = st_reg.sw_armed & (st_reg.timer == st_reg.compare);
         end
         else if (st_reg.mode[CDM_MD_SWA])
         begin
            c_evt = st_reg.hw_armed & (st_reg.timer >= st_reg.compare);
         end
         else
         begin
            c_evt = (st_reg.timer == st_reg.compare);
         end
      end

      // Step timer: count, wrap, reset by events
      if (tick)
      begin
         st_next.timer = st_reg.timer + 8'h01;
         if (st_reg.timer == CDM_TIMER_MAX && six_step)
         begin
            st_next.status[CDM_ST_OVF] = 1'b1;
         end
      end
      if (c_evt && !st_reg.mode[CDM_MD_SWA])
      begin
         st_next.timer = 8'h00;
      end

      // Captures on zero crossing
      if (zero_cross_hw)
      begin
         st_next.zlatest = st_reg.timer;
         st_next.zprev   = st_reg.zlatest;
      end
      else if (zs_evt)
      begin
         st_next.zprev = st_reg.zlatest;
      end
      if (z_evt)
      begin
         st_next.timer     = 8'h00;
         st_next.mult_pend = 2'h1;
         st_next.status[CDM_ST_ZERO] = 1'b1;
      end
      else
      begin
         st_next.mult_pend = {st_reg.mult_pend[0], 1'b0};
      end

      // Demag capture and simulated demag compare
      st_next.dsim_pulse = cke & st_reg.mode[CDM_MD_DSIM]
                           & (st_reg.timer == st_reg.demag)
                           & (st_reg.demag != 8'h00);
      if (demag_hw)
      begin
         st_next.demag = st_reg.timer;
      end
      if (demag_hw | st_next.dsim_pulse)
      begin
         st_next.status[CDM_ST_DEMAG] = 1'b1;
      end

      // Automatic compare load after the product settles
      if (st_reg.mult_pend[1] && st_reg.mode[CDM_MD_SWA] && !st_reg.mode[CDM_MD_SC])
      begin
         st_next.hw_armed = 1'b1;
         if (mult_out <= st_next.timer)
         begin
            st_next.compare = st_next.timer;
         end
         else
         begin
            st_next.compare = mult_out;
         end
      end

      // Commutation consequences and ratio rescale
      st_next.comm_pulse = c_evt;
      st_next.zsim_pulse = zs_evt;
      if (c_evt)
      begin
         st_next.sw_armed = 1'b0;
         st_next.hw_armed = 1'b0;
         st_next.status[CDM_ST_COMM] = 1'b1;
         if (st_reg.mode[CDM_MD_RPI] && st_reg.ratio != CDM_RATIO_MAX)
         begin
            st_next.ratio   = st_reg.ratio + 4'h1;
            st_next.timer   = st_next.timer >> 1;
            st_next.zlatest = st_next.zlatest >> 1;
            st_next.zprev   = st_next.zprev >> 1;
            st_next.demag   = st_next.demag >> 1;
            st_next.compare = st_next.compare >> 1;
         end
         else if (st_reg.mode[CDM_MD_RMI] && st_reg.ratio != CDM_RATIO_MIN)
         begin
            st_next.ratio   = st_reg.ratio - 4'h1;
            st_next.timer   = st_next.timer << 1;
            st_next.zlatest = st_next.zlatest << 1;
            st_next.zprev   = st_next.zprev << 1;
            st_next.demag   = st_next.demag << 1;
            st_next.compare = st_next.compare << 1;
         end
         st_next.mode[CDM_MD_RPI] = 1'b0;
         st_next.mode[CDM_MD_RMI] = 1'b0;
      end

      // Register writes; hardware sets win over status clears
      if (wr)
      begin
         unique case (avs_address)
            CDM_OFF_PINCFG:  st_next.pincfg = wbyte;
            CDM_OFF_MODE:
            begin
               st_next.mode[5:0] = wbyte[5:0];
               if (!(wbyte[CDM_MD_RPI] && wbyte[CDM_MD_RMI]))
               begin
                  st_next.mode[CDM_MD_RPI] = st_reg.mode[CDM_MD_RPI] | wbyte[CDM_MD_RPI];
                  st_next.mode[CDM_MD_RMI] = st_reg.mode[CDM_MD_RMI] | wbyte[CDM_MD_RMI];
                  if (st_next.mode[CDM_MD_RPI] && st_next.mode[CDM_MD_RMI])
                  begin
                     st_next.mode[7:6] = st_reg.mode[7:6];
                  end
               end
            end
            CDM_OFF_RATIO:
            begin
               if (!cke)
               begin
                  st_next.ratio = wbyte[3:0];
               end
            end
            CDM_OFF_TIMER:
            begin
               if (!cke)
               begin
                  st_next.timer = wbyte;
               end
            end
            CDM_OFF_DEMAG:   st_next.demag = wbyte;
            CDM_OFF_ZLATEST: st_next.zlatest = wbyte;
            CDM_OFF_ZPREV:   st_next.zprev = wbyte;
            CDM_OFF_COMPARE:
            begin
               st_next.compare  = wbyte;
               st_next.sw_armed = 1'b1;
            end
            CDM_OFF_WEIGHT:  st_next.weight = wbyte;
            CDM_OFF_STATUS:  st_next.status = st_next.status; // Cleared above
            default:         st_next.weight = st_next.weight;
         endcase
      end

      // Rotor pin configuration from the pin setup register
      onehot = 3'h1 << insel;
      st_next.analog  = 3'h0;
      st_next.digital = 3'h0;
      st_next.stdio   = 3'h0;
      st_next.ground  = 3'h0;
      st_next.comp_on = st_reg.pincfg[CDM_PC_COMP_EN];
      if (!release_b)
      begin
         if (six_step && !sensor_b && insel != CDM_IS_ALL_STD)
         begin
            st_next.analog = onehot;
            st_next.ground = st_reg.pincfg[CDM_PC_GROUND] ? ~onehot : 3'h0;
         end
         else if (insel != CDM_IS_ALL_STD)
         begin
            st_next.digital = onehot;
            st_next.stdio   = six_step ? ~onehot : 3'h0;
         end
      end
      else if (six_step)
      begin
         if (insel != CDM_IS_ALL_STD)
         begin
            st_next.analog  = onehot;
            st_next.stdio   = ~onehot;
            st_next.comp_on = 1'b1;
         end
         else
         begin
            st_next.stdio = 3'h7;
         end
      end
      else if (insel != CDM_IS_ALL_STD)
      begin
         st_next.digital = onehot;
         st_next.stdio   = ~onehot;
      end
      else
      begin
         st_next.stdio   = 3'h7;
         st_next.comp_on = 1'b0;
      end
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         st_reg         <= '0;
         st_reg.bus     <= CDM_BUS_IDLE;
         st_reg.pincfg  <= CDM_RST_PINCFG;
         st_reg.mode    <= CDM_RST_MODE;
         st_reg.ratio   <= CDM_RST_RATIO;
         st_reg.weight  <= CDM_RST_WEIGHT;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs
   assign avs_waitrequest   = (avs_read | avs_write) && (st_reg.bus == CDM_BUS_IDLE);
   assign avs_readdata      = st_reg.rdata;
   assign rotor_digital     = pin_level;
   assign pin_analog_sel    = st_reg.analog;
   assign pin_digital_sel   = st_reg.digital;
   assign pin_std_io        = st_reg.stdio;
   assign pin_ground_o      = 3'h0;
   assign pin_ground_oe     = st_reg.ground;
   assign phase_comp_on     = st_reg.comp_on;
   assign commutation_event = st_reg.comm_pulse;
   assign sim_zero_event    = st_reg.zsim_pulse;
   assign sim_demag_event   = st_reg.dsim_pulse;
   assign speed_mode        = (st_reg.pincfg[CDM_PC_TES_LO +: 2] != 2'h0);
endmodule

// ---- rtl/cdm_pkg.sv ----
// Constants shared by the commutation delay manager design.
// Assumes Avalon-MM word addressing with 32-bit data.
package cdm_pkg;
   // Register word offsets
   localparam logic [3:0] CDM_OFF_PINCFG  = 4'h0;
   localparam logic [3:0] CDM_OFF_MODE    = 4'h1;
   localparam logic [3:0] CDM_OFF_RATIO   = 4'h2;
   localparam logic [3:0] CDM_OFF_TIMER   = 4'h3;
   localparam logic [3:0] CDM_OFF_DEMAG   = 4'h4;
   localparam logic [3:0] CDM_OFF_ZLATEST = 4'h5;
   localparam logic [3:0] CDM_OFF_ZPREV   = 4'h6;
   localparam logic [3:0] CDM_OFF_COMPARE = 4'h7;
   localparam logic [3:0] CDM_OFF_WEIGHT  = 4'h8;
   localparam logic [3:0] CDM_OFF_STATUS  = 4'h9;
   // Pin configuration register fields
   localparam int CDM_PC_RELEASE = 0;
   localparam int CDM_PC_TES_LO  = 1;
   localparam int CDM_PC_SENSOR  = 3;
   localparam int CDM_PC_IS_LO   = 4;
   localparam int CDM_PC_GROUND  = 6;
   localparam int CDM_PC_COMP_EN = 7;
   // Mode register fields
   localparam int CDM_MD_SWA  = 0;
   localparam int CDM_MD_SC   = 1;
   localparam int CDM_MD_CKE  = 2;
   localparam int CDM_MD_DCB  = 3;
   localparam int CDM_MD_ZSIM = 4;
   localparam int CDM_MD_DSIM = 5;
   localparam int CDM_MD_RPI  = 6;
   localparam int CDM_MD_RMI  = 7;
   // Status register fields
   localparam int CDM_ST_COMM  = 0;
   localparam int CDM_ST_ZERO  = 1;
   localparam int CDM_ST_DEMAG = 2;
   localparam int CDM_ST_OVF   = 3;
   // Reset values
   localparam logic [7:0] CDM_RST_PINCFG = 8'h00;
   localparam logic [7:0] CDM_RST_MODE   = 8'h00;
   localparam logic [3:0] CDM_RST_RATIO  = 4'h0;
   localparam logic [7:0] CDM_RST_BYTE   = 8'h00;
   localparam logic [7:0] CDM_RST_WEIGHT = 8'h80;
   // Input select code that releases all pins
   localparam logic [1:0] CDM_IS_ALL_STD = 2'h3;
   // Prescaler ratio limits
   localparam logic [3:0] CDM_RATIO_MAX = 4'hF;
   localparam logic [3:0] CDM_RATIO_MIN = 4'h0;
   // Timer full-scale value
   localparam logic [7:0] CDM_TIMER_MAX = 8'hFF;
   // Bus answer states
   typedef enum logic [0:0] {
      CDM_BUS_IDLE = 1'b0,
      CDM_BUS_ACK  = 1'b1
   } cdm_bus_t;
endpackage

// ---- rtl/cdm_sync3.sv ----
// Three-stage synchroniser for one pin input.
// Assumes an asynchronous level; output changes when stages two and three agree.
`timescale 1ns/10ps
module cdm_sync3
   import cdm_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Pin and filtered level
   input  wire logic pin_in,
   output logic      level_out
);
   logic [2:0] stage_reg;
   logic       level_reg;

   // Shift chain; first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         stage_reg <= 3'h0;
         level_reg <= 1'b0;
      end
      else
      begin
         stage_reg <= {stage_reg[1:0], pin_in};
         if (stage_reg[1] == stage_reg[2])
         begin
            level_reg <= stage_reg[2];
         end
      end
   end

   assign level_out = level_reg;
endmodule

// ---- rtl/cdm_mult8.sv ----
// Registered 8x8 multiplier returning the product divided by 256.
// Assumes operands from the same clock domain; one cycle latency.
`timescale 1ns/10ps
module cdm_mult8
   import cdm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Operands and scaled product
   input  wire logic [7:0] factor_a,
   input  wire logic [7:0] factor_b,
   output logic [7:0]      scaled_out
);
   logic [15:0] product;
   logic [7:0]  scaled_reg;

   // Full product, upper byte kept
   assign product = factor_a * factor_b;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         scaled_reg <= CDM_RST_BYTE;
      end
      else
      begin
         scaled_reg <= product[15:8];
      end
   end

   assign scaled_out = scaled_reg;
endmodule

// ---- dv/cdm_delay_manager_props.sv ----
// Port checker for the commutation delay manager.
// Assumes binding to cdm_delay_manager; sees only its ports.
`timescale 1ns/10ps
module cdm_delay_manager_props
   import cdm_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Pin setup and events
   input wire logic [2:0]  pin_analog_sel,
   input wire logic [2:0]  pin_digital_sel,
   input wire logic [2:0]  pin_std_io,
   input wire logic [2:0]  pin_ground_o,
   input wire logic [2:0]  pin_ground_oe,
   input wire logic        phase_comp_on,
   input wire logic        commutation_event,
   input wire logic        speed_mode
);
   typedef struct packed {logic sc; logic armed; logic ok; logic [7:0] cfg;} cdm_chk_t;
   cdm_chk_t chk_reg;
   cdm_chk_t chk_next;
   logic     acc;
   assign acc = avs_write && !avs_waitrequest;
   // Mirror of mode, arming and pin setup
   always_comb
   begin
      chk_next = chk_reg;
      chk_next.ok = !(acc && avs_address == CDM_OFF_PINCFG);
      if (acc && avs_address == CDM_OFF_MODE)
         chk_next.sc = avs_writedata[CDM_MD_SC];
      if (acc && avs_address == CDM_OFF_PINCFG)
         chk_next.cfg = avs_writedata[7:0];
      if (commutation_event)
         chk_next.armed = 1'b0;
      if (acc && avs_address == CDM_OFF_COMPARE)
         chk_next.armed = 1'b1;
   end
   // Mirror register
   always_ff @(posedge clk)
   begin
      if (!resetn)
         chk_reg <= '0;
      else
         chk_reg <= chk_next;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_READ_ZERO: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0
      && (avs_address < 4'hA || avs_readdata[7:0] == 8'h00)) else $error("Read data not zero");
   AST_ANALOG_PICK: assert property (
      chk_reg.ok && chk_reg.cfg[2:0] == 3'h1 && chk_reg.cfg[5:4] != 2'h3
      |-> pin_analog_sel == (3'h1 << chk_reg.cfg[5:4]) && pin_std_io == ~pin_analog_sel
      && phase_comp_on) else $error("Released analog setup wrong");
   AST_ALL_STD: assert property (
      chk_reg.ok && chk_reg.cfg[2:0] == 3'h1 && chk_reg.cfg[5:4] == 2'h3
      |-> pin_std_io == 3'h7 && pin_analog_sel == 3'h0 && pin_digital_sel == 3'h0)
      else $error("Released pins not standard");
   AST_COMP_OFF: assert property (
      chk_reg.ok && chk_reg.cfg[0] && chk_reg.cfg[2:1] != 2'h0 && chk_reg.cfg[5:4] == 2'h3
      |-> pin_std_io == 3'h7 && !phase_comp_on) else $error("Comparator not off");
   AST_GROUND: assert property (
      chk_reg.ok && chk_reg.cfg[3:0] == 4'h0 && chk_reg.cfg[5:4] != 2'h3
      |-> pin_ground_oe == (chk_reg.cfg[6] ? ~pin_analog_sel : 3'h0) && pin_ground_o == 3'h0)
      else $error("Unselected pin grounding wrong");
   AST_SPEED_FLAG: assert property (
      chk_reg.ok |-> speed_mode == (chk_reg.cfg[2:1] != 2'h0)) else $error("Speed flag wrong");
   AST_SPEED_NO_COMM: assert property (
      speed_mode && $past(speed_mode) |-> !commutation_event) else $error("Commutation in speed");
   AST_SIM_ARMED: assert property (
      commutation_event |-> !$past(chk_reg.sc) || $past(chk_reg.armed))
      else $error("Simulated commutation without compare write");
   AST_COMM_PULSE: assert property (
      commutation_event |=> !commutation_event) else $error("Commutation pulse too long");
endmodule
bind cdm_delay_manager cdm_delay_manager_props i_props (.clk, .resetn, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .pin_analog_sel, .pin_digital_sel,
   .pin_std_io, .pin_ground_o, .pin_ground_oe, .phase_comp_on, .commutation_event, .speed_mode);

// ---- dv/cdm_motor_model.sv ----
// Behavioural motor: rotating sensor levels and event pulses.
// Assumes one-cycle requests from the bench on clk.
`timescale 1ns/10ps
module cdm_motor_model
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Requests
   input  wire logic zc_req,
   input  wire logic dm_req,
   // Events and pins
   output logic      zero_cross_hw = 1'b0,
   output logic      demag_hw = 1'b0,
   output logic      rotor_input_a = 1'b1,
   output logic      rotor_input_b = 1'b0,
   output logic      rotor_input_c = 1'b0
);
   // Sensor pattern steps at each zero crossing
   always @(posedge clk)
   begin
      zero_cross_hw <= zc_req && resetn;
      demag_hw <= dm_req && resetn;
      if (zc_req)
         {rotor_input_c, rotor_input_b, rotor_input_a} <= {rotor_input_b, rotor_input_a, ~rotor_input_c};
   end
endmodule

// ---- dv/cdm_delay_manager_tb.sv ----
// Directed bench for the commutation delay manager.
// Assumes the motor model on event and rotor pins.
`timescale 1ns/10ps
module cdm_delay_manager_tb
   import cdm_pkg::*;
;
   logic        clk, resetn, avs_read, avs_write, avs_waitrequest, zc_req, dm_req;
   logic        zero_cross_hw, demag_hw, rotor_input_a, rotor_input_b, rotor_input_c;
   logic        phase_comp_on, commutation_event, sim_zero_event, sim_demag_event, speed_mode;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [2:0]  rotor_digital, pin_analog_sel, pin_digital_sel, pin_std_io, pin_ground_o;
   logic [2:0]  pin_ground_oe, a;
   logic [7:0]  rv, t1;
   int          fail_count = 0, tests_run = 0, n;
   cdm_delay_manager i_dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .zero_cross_hw, .demag_hw, .rotor_input_a, .rotor_input_b,
      .rotor_input_c, .rotor_digital, .pin_analog_sel, .pin_digital_sel, .pin_std_io,
      .pin_ground_o, .pin_ground_oe, .phase_comp_on, .commutation_event, .sim_zero_event,
      .sim_demag_event, .speed_mode);
   cdm_motor_model i_motor (.clk, .resetn, .zc_req, .dm_req, .zero_cross_hw, .demag_hw,
      .rotor_input_a, .rotor_input_b, .rotor_input_c);
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] adr, input logic [7:0] d);
      logic w;
      @(posedge clk);
      avs_address <= adr;
      avs_writedata <= {24'h0, d};
      avs_read <= !wr;
      avs_write <= wr;
      do
      begin
         @(posedge clk);
         w = avs_waitrequest;
         rv = avs_readdata[7:0];
      end
      while (w !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic count_comm(input int cyc);
      n = 0;
      repeat (cyc)
      begin
         @(negedge clk);
         if (commutation_event === 1'b1)
            n++;
      end
   endtask
   // Event request, then a fixed gap of edges
   task automatic pulse(input logic z, input int gap);
      @(posedge clk);
      {zc_req, dm_req} <= z ? 2'b10 : 2'b01;
      @(posedge clk);
      {zc_req, dm_req} <= 2'b00;
      repeat (gap) @(posedge clk);
   endtask
   task automatic cfg(input logic [7:0] v, input logic [2:0] an, st, gn, input logic cp);
      bus(1'b1, CDM_OFF_PINCFG, v);
      repeat (2) @(negedge clk);
      chk("analog", {5'h0, pin_analog_sel}, {5'h0, an});
      chk("std_io", {5'h0, pin_std_io}, {5'h0, st});
      chk("ground", {5'h0, pin_ground_oe}, {5'h0, gn});
      chk("comp", {7'h0, phase_comp_on}, {7'h0, cp});
   endtask
   task automatic give_verdict();
      $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Watchdog
   initial
   begin
      #400000;
      fail_count++;
      give_verdict();
   end
   // Main sequence
   initial
   begin
      resetn = 1'b0;
      {avs_read, avs_write, zc_req, dm_req} = 4'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      bus(1'b0, CDM_OFF_WEIGHT, 8'h00);
      chk("weight", rv, 8'h80);
      bus(1'b1, 4'hA, 8'h5A);
      bus(1'b0, 4'hA, 8'h00);
      chk("unmapped", rv, 8'h00);
      bus(1'b1, CDM_OFF_MODE, 8'h06);
      count_comm(100);
      chk("no_arm", 8'(n), 8'h00);
      bus(1'b1, CDM_OFF_COMPARE, 8'h08);
      count_comm(300);
      chk("sim_once", 8'(n), 8'h01);
      bus(1'b1, CDM_OFF_MODE, 8'h04);
      count_comm(400);
      chk("periodic", {7'h0, n > 1}, 8'h01);
      bus(1'b0, CDM_OFF_COMPARE, 8'h00);
      chk("cmp_sw", rv, 8'h08);
      bus(1'b1, CDM_OFF_MODE, 8'h05);
      bus(1'b1, CDM_OFF_COMPARE, 8'h33);
      bus(1'b0, CDM_OFF_COMPARE, 8'h00);
      chk("cmp_auto", rv, 8'h33);
      bus(1'b1, CDM_OFF_PINCFG, 8'h02);
      bus(1'b1, CDM_OFF_COMPARE, 8'h08);
      bus(1'b1, CDM_OFF_MODE, 8'h04);
      count_comm(300);
      chk("speed_comm", 8'(n), 8'h00);
      chk("speed_flag", {7'h0, speed_mode}, 8'h01);
      for (int k = 0; k < 3; k++)
      begin
         a = 3'h1 << k;
         cfg(8'h01 | 8'(k << 4), a, ~a, 3'h0, 1'b1);
         cfg(8'h40 | 8'(k << 4), a, 3'h0, ~a, 1'b0);
         cfg(8'(k << 4), a, 3'h0, 3'h0, 1'b0);
      end
      cfg(8'h31, 3'h0, 3'h7, 3'h0, 1'b0);
      cfg(8'hB1, 3'h0, 3'h7, 3'h0, 1'b1);
      cfg(8'hB3, 3'h0, 3'h7, 3'h0, 1'b0);
      bus(1'b1, CDM_OFF_PINCFG, 8'h00);
      bus(1'b1, CDM_OFF_MODE, 8'h00);
      bus(1'b1, CDM_OFF_RATIO, 8'h00);
      bus(1'b1, CDM_OFF_MODE, 8'h0D);
      pulse(1'b1, 19);
      pulse(1'b1, 39);
      pulse(1'b1, 9);
      pulse(1'b0, 0);
      count_comm(40);
      chk("auto_comm", 8'(n), 8'h01);
      bus(1'b0, CDM_OFF_ZLATEST, 8'h00);
      chk("zlatest", rv, 8'h28);
      bus(1'b0, CDM_OFF_ZPREV, 8'h00);
      chk("zprev", rv, 8'h14);
      bus(1'b0, CDM_OFF_DEMAG, 8'h00);
      chk("demag", rv, 8'h0A);
      bus(1'b0, CDM_OFF_COMPARE, 8'h00);
      chk("auto_cmp", rv, 8'h14);
      chk("rotor", {5'h0, rotor_digital}, {5'h0, rotor_input_c, rotor_input_b, rotor_input_a});
      bus(1'b1, CDM_OFF_MODE, 8'h00);
      bus(1'b0, CDM_OFF_TIMER, 8'h00);
      t1 = rv;
      count_comm(20);
      bus(1'b0, CDM_OFF_TIMER, 8'h00);
      chk("hold", rv, t1);
      bus(1'b1, CDM_OFF_RATIO, 8'h03);
      bus(1'b1, CDM_OFF_MODE, 8'h04);
      bus(1'b1, CDM_OFF_RATIO, 8'h05);
      bus(1'b0, CDM_OFF_RATIO, 8'h00);
      chk("ratio", rv, 8'h03);
      bus(1'b0, CDM_OFF_TIMER, 8'h00);
      t1 = rv;
      count_comm(40);
      bus(1'b0, CDM_OFF_TIMER, 8'h00);
      chk("runs", {7'h0, rv != t1}, 8'h01);
      bus(1'b1, CDM_OFF_MODE, 8'h44);
      count_comm(2200);
      bus(1'b0, CDM_OFF_RATIO, 8'h00);
      chk("ratio_up", rv, 8'h04);
      bus(1'b0, CDM_OFF_COMPARE, 8'h00);
      chk("cmp_shift", rv, 8'h0A);
      bus(1'b1, CDM_OFF_COMPARE, 8'h20);
      bus(1'b1, CDM_OFF_MODE, 8'h14);
      count_comm(700);
      bus(1'b0, CDM_OFF_ZPREV, 8'h00);
      chk("zsim_prev", rv, 8'h14);
      give_verdict();
   end
endmodule
